/* count_signal_decoder.sv */
// Count signal decoder: encoder tracks to up and down count pulses, with AXI4-Lite registers
// Summary of operation
// - Counting works without a reference track
// - Incremental mode: reference mark loads start or captures count
// - Direction follows A and B edge order
// - Configurable inversion swaps up and down
// - Pulse mode: each A pulse counts once
// - Pulse mode: B high down, low up
// - Up/down mode: A up, B down
// - Evaluation single, double or quadruple selectable
// - Incremental mode: simultaneous A and B change flags fault
// - Single: A rising, B low counts up
// - Single: A falling, B low counts down
// - Double: every A edge counts
// - Quadruple: every A and B edge counts
// - Wire breaks reported as signal errors
// - Enabled diagnostic interrupt on signal error
`timescale 1ns/100ps
module count_signal_decoder (
	input  wire logic        REF_CLK_IN,          // 200 MHz module clock
	input  wire logic        RESET_N_IN,          // Asynchronous reset, active low
	input  wire logic        ENC_A_IN,            // Track A, pulse or up input
	input  wire logic        ENC_B_IN,            // Track B, direction or down input
	input  wire logic        ENC_N_IN,            // Reference mark, may stay unused
	input  wire logic [2:0]  WIRE_BREAK_IN,       // Broken wire seen on A, B, N
	input  wire logic [7:0]  S_AXI_AWADDR_IN,     // Write address
	input  wire logic        S_AXI_AWVALID_IN,    // Write address valid
	output logic             S_AXI_AWREADY_OUT,   // Write address ready
	input  wire logic [31:0] S_AXI_WDATA_IN,      // Write data
	input  wire logic [3:0]  S_AXI_WSTRB_IN,      // Write byte strobes
	input  wire logic        S_AXI_WVALID_IN,     // Write data valid
	output logic             S_AXI_WREADY_OUT,    // Write data ready
	output logic [1:0]       S_AXI_BRESP_OUT,     // Write response
	output logic             S_AXI_BVALID_OUT,    // Write response valid
	input  wire logic        S_AXI_BREADY_IN,     // Write response ready
	input  wire logic [7:0]  S_AXI_ARADDR_IN,     // Read address
	input  wire logic        S_AXI_ARVALID_IN,    // Read address valid
	output logic             S_AXI_ARREADY_OUT,   // Read address ready
	output logic [31:0]      S_AXI_RDATA_OUT,     // Read data
	output logic [1:0]       S_AXI_RRESP_OUT,     // Read response
	output logic             S_AXI_RVALID_OUT,    // Read data valid
	input  wire logic        S_AXI_RREADY_IN,     // Read data ready
	output logic             COUNT_UP_OUT,        // One-cycle up count pulse
	output logic             COUNT_DOWN_OUT,      // One-cycle down count pulse
	output logic             LOAD_START_OUT,      // Load counter with start value
	output logic             CAPTURE_OUT,         // Copy count to capture register
	output logic             ENCODER_FAULT_FLAG_OUT, // Sticky invalid transition flag
	output logic             SIGNAL_ERROR_OUT,    // Sticky encoder signal error
	output logic             DIAG_INT_OUT         // One-cycle diagnostic interrupt
);
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// Word match on the register offset, low address bits ignored
	function automatic logic at_ofs(input logic [7:0] addr, input logic [7:0] ofs);
		return addr[cnt_dec_pkg::ADDR_W-1:2] == ofs[cnt_dec_pkg::ADDR_W-1:2];
	endfunction : at_ofs
	// Byte lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			res[i*8 +: 8] = strb[i] ? data[i*8 +: 8] : res[i*8 +: 8];
		end
		return res;
	endfunction : merge
	logic [cnt_dec_pkg::NUM_IN-1:0] sync1, sync2, sync3;  // Pin synchroniser chain
	logic [cnt_dec_pkg::NUM_IN-1:0] filt, filt_q;         // Agreed level and its last value
	logic [cnt_dec_pkg::NUM_IN-1:0] next_filt;            // Filter next value
	logic [2:0]                     settle, next_settle;  // Start-up settling count
	logic                           armed;                // Filters hold real pin levels
	// Three-stage synchroniser; a change counts once stages two and three agree
	always_comb begin
		next_filt = (sync2 & sync3) | (filt & (sync2 ^ sync3));
		next_settle = armed ? settle : 3'(settle + 3'h1);
	end
	// Registers of the input path
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			sync1  <= '0;
			sync2  <= '0;
			sync3  <= '0;
			filt   <= '0;
			filt_q <= '0;
			settle <= '0;
		end else begin
			sync1  <= {WIRE_BREAK_IN, ENC_N_IN, ENC_B_IN, ENC_A_IN};
			sync2  <= sync1;
			sync3  <= sync2;
			filt   <= next_filt;
			filt_q <= filt;
			settle <= next_settle;
		end
	end
	// Edges are masked until the filters settle, so a pin high at reset is no edge
	assign armed = (settle == cnt_dec_pkg::SETTLE_MAX);
	logic [31:0]            ctrl;          // Control register
	logic                   st_fault;      // Sticky encoder fault
	logic                   st_sigerr;     // Sticky signal error
	cnt_dec_pkg::enc_mode_t cur_mode;      // Selected encoder kind
	cnt_dec_pkg::eval_t     cur_eval;      // Selected evaluation
	cnt_dec_pkg::ref_act_t  cur_ref;       // Selected reference action
	logic                   a_lvl, b_lvl;  // Filtered track levels
	logic                   a_edge, b_edge, a_rise, b_rise, n_rise;
	logic [cnt_dec_pkg::NUM_BRK-1:0] brk_rise; // New wire breaks
	assign cur_mode = cnt_dec_pkg::enc_mode_t'(ctrl[cnt_dec_pkg::CTRL_MODE +: 2]);
	assign cur_eval = cnt_dec_pkg::eval_t'(ctrl[cnt_dec_pkg::CTRL_EVAL +: 2]);
	assign cur_ref  = cnt_dec_pkg::ref_act_t'(ctrl[cnt_dec_pkg::CTRL_REF +: 2]);
	assign a_lvl    = filt[cnt_dec_pkg::IDX_A];
	assign b_lvl    = filt[cnt_dec_pkg::IDX_B];
	assign a_edge   = armed & (a_lvl ^ filt_q[cnt_dec_pkg::IDX_A]);
	assign b_edge   = armed & (b_lvl ^ filt_q[cnt_dec_pkg::IDX_B]);
	assign a_rise   = a_edge & a_lvl;
	assign b_rise   = b_edge & b_lvl;
	assign n_rise   = armed & filt[cnt_dec_pkg::IDX_N] & ~filt_q[cnt_dec_pkg::IDX_N];
	assign brk_rise = {cnt_dec_pkg::NUM_BRK{armed}}
		& filt[cnt_dec_pkg::IDX_BRK +: cnt_dec_pkg::NUM_BRK]
		& ~filt_q[cnt_dec_pkg::IDX_BRK +: cnt_dec_pkg::NUM_BRK];
	logic next_up, next_dn, next_load, next_cap; // Next pulse outputs
	logic fault_set, sigerr_set, next_diag;      // Events of this cycle
	logic up, dn;                                // Raw direction before inversion
	// Decoder: in incremental mode, edge of one track and level of the other give the direction
	always_comb begin
		up        = 1'b0;
		dn        = 1'b0;
		fault_set = 1'b0;
		next_load = 1'b0;
		next_cap  = 1'b0;
		unique case (cur_mode)
			cnt_dec_pkg::MODE_INC: begin
				if (a_edge & b_edge) begin
					fault_set = 1'b1;
				end else begin
					unique case (cur_eval)
						cnt_dec_pkg::EVAL_SINGLE: begin
							if (a_edge & ~b_lvl) begin // Edges of A with B high are ignored
								up = a_lvl;
								dn = ~a_lvl;
							end
						end
						cnt_dec_pkg::EVAL_DOUBLE: begin
							if (a_edge) begin
								up = a_lvl ^ b_lvl;
								dn = ~(a_lvl ^ b_lvl);
							end
						end
						cnt_dec_pkg::EVAL_QUAD: begin
							if (a_edge) begin
								up = a_lvl ^ b_lvl;
								dn = ~(a_lvl ^ b_lvl);
							end else if (b_edge) begin
								up = ~(a_lvl ^ b_lvl);
								dn = a_lvl ^ b_lvl;
							end
						end
						default: begin // Unused evaluation code counts nothing
						end
					endcase
				end
				// Mark is optional; tracks count alone when it never moves
				if (n_rise) begin
					next_load = (cur_ref == cnt_dec_pkg::REF_LOAD);
					next_cap  = (cur_ref == cnt_dec_pkg::REF_CAPTURE);
				end
			end
			cnt_dec_pkg::MODE_PULSE: begin
				if (a_rise) begin
					// Direction from B if wired, else from software
					dn = ctrl[cnt_dec_pkg::CTRL_DIREN] ? b_lvl
						: ctrl[cnt_dec_pkg::CTRL_SWDIR];
					up = ~dn;
				end
			end
			cnt_dec_pkg::MODE_UPDOWN: begin
				up = a_rise;
				dn = b_rise;
			end
			default: begin // Unused encoder code counts nothing
			end
		endcase
		// Up and down in one cycle cancel, the net position is unchanged
		next_up = (ctrl[cnt_dec_pkg::CTRL_INV] ? dn : up) & ~(up & dn);
		next_dn = (ctrl[cnt_dec_pkg::CTRL_INV] ? up : dn) & ~(up & dn);
		sigerr_set = ctrl[cnt_dec_pkg::CTRL_WIRE] & (|brk_rise);
		next_diag  = sigerr_set & ctrl[cnt_dec_pkg::CTRL_DIAG];
	end
	// Registered pulse outputs
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			COUNT_UP_OUT   <= 1'b0;
			COUNT_DOWN_OUT <= 1'b0;
			LOAD_START_OUT <= 1'b0;
			CAPTURE_OUT    <= 1'b0;
			DIAG_INT_OUT   <= 1'b0;
		end else begin
			COUNT_UP_OUT   <= next_up;
			COUNT_DOWN_OUT <= next_dn;
			LOAD_START_OUT <= next_load;
			CAPTURE_OUT    <= next_cap;
			DIAG_INT_OUT   <= next_diag;
		end
	end
	logic        aw_held, w_held;         // Address or data waiting for its partner
	logic [7:0]  aw_addr;                 // Held write address
	logic [31:0] w_data;                  // Held write data
	logic [3:0]  w_strb;                  // Held byte strobes
	logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0]  next_aw_addr;
	logic [31:0] next_w_data, next_ctrl, next_rdata, status_word;
	logic [3:0]  next_w_strb;
	logic [1:0]  next_bresp, next_rresp;
	logic        next_fault, next_sigerr, do_write;
	// Status word: sticky flags and live filtered levels
	always_comb begin
		status_word = '0;
		status_word[cnt_dec_pkg::STAT_FAULT]  = st_fault;
		status_word[cnt_dec_pkg::STAT_SIGERR] = st_sigerr;
		status_word[cnt_dec_pkg::STAT_LVL +: 3] = filt[cnt_dec_pkg::IDX_N:cnt_dec_pkg::IDX_A];
	end
	// AXI4-Lite slave; address and data are taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = S_AXI_BVALID_OUT & ~S_AXI_BREADY_IN;
		next_bresp   = S_AXI_BRESP_OUT;
		next_rvalid  = S_AXI_RVALID_OUT & ~S_AXI_RREADY_IN;
		next_rdata   = S_AXI_RDATA_OUT;
		next_rresp   = S_AXI_RRESP_OUT;
		next_ctrl    = ctrl;
		next_fault   = st_fault;
		next_sigerr  = st_sigerr;
		do_write     = aw_held & w_held & ~S_AXI_BVALID_OUT;
		if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT) begin
			next_aw_held = 1'b1;
			next_aw_addr = S_AXI_AWADDR_IN;
		end
		if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT) begin
			next_w_held = 1'b1;
			next_w_data = S_AXI_WDATA_IN;
			next_w_strb = S_AXI_WSTRB_IN;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = cnt_dec_pkg::RESP_OKAY;
			if (at_ofs(aw_addr, cnt_dec_pkg::OFS_CTRL)) begin
				next_ctrl = merge(ctrl, w_data, w_strb) & cnt_dec_pkg::CTRL_MASK;
			end else if (at_ofs(aw_addr, cnt_dec_pkg::OFS_STATUS)) begin
				// Write one to clear, low byte only
				if (w_strb[0]) begin
					next_fault  = st_fault & ~w_data[cnt_dec_pkg::STAT_FAULT];
					next_sigerr = st_sigerr & ~w_data[cnt_dec_pkg::STAT_SIGERR];
				end
			end else begin
				next_bresp = cnt_dec_pkg::RESP_SLVERR;
			end
		end
		// A new event wins over a clear in the same cycle
		next_fault  = next_fault | fault_set;
		next_sigerr = next_sigerr | sigerr_set;
		if (S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT) begin
			next_rvalid = 1'b1;
			next_rresp  = cnt_dec_pkg::RESP_OKAY;
			if (at_ofs(S_AXI_ARADDR_IN, cnt_dec_pkg::OFS_CTRL)) begin
				next_rdata = ctrl;
			end else if (at_ofs(S_AXI_ARADDR_IN, cnt_dec_pkg::OFS_STATUS)) begin
				next_rdata = status_word;
			end else begin
				next_rdata = '0;
				next_rresp = cnt_dec_pkg::RESP_SLVERR;
			end
		end
	end
	// Bus and register state
	always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			aw_held           <= 1'b0;
			aw_addr           <= '0;
			w_held            <= 1'b0;
			w_data            <= '0;
			w_strb            <= '0;
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT  <= 1'b0;
			S_AXI_BVALID_OUT  <= 1'b0;
			S_AXI_BRESP_OUT   <= cnt_dec_pkg::RESP_OKAY;
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT  <= 1'b0;
			S_AXI_RDATA_OUT   <= '0;
			S_AXI_RRESP_OUT   <= cnt_dec_pkg::RESP_OKAY;
			ctrl              <= cnt_dec_pkg::CTRL_RESET;
			st_fault          <= 1'b0;
			st_sigerr         <= 1'b0;
		end else begin
			aw_held           <= next_aw_held;
			aw_addr           <= next_aw_addr;
			w_held            <= next_w_held;
			w_data            <= next_w_data;
			w_strb            <= next_w_strb;
			S_AXI_AWREADY_OUT <= ~next_aw_held;
			S_AXI_WREADY_OUT  <= ~next_w_held;
			S_AXI_BVALID_OUT  <= next_bvalid;
			S_AXI_BRESP_OUT   <= next_bresp;
			S_AXI_ARREADY_OUT <= ~next_rvalid;
			S_AXI_RVALID_OUT  <= next_rvalid;
			S_AXI_RDATA_OUT   <= next_rdata;
			S_AXI_RRESP_OUT   <= next_rresp;
			ctrl              <= next_ctrl;
			st_fault          <= next_fault;
			st_sigerr         <= next_sigerr;
		end
	end
	// Flags go out straight from their sticky flip-flops
	assign ENCODER_FAULT_FLAG_OUT = st_fault;
	assign SIGNAL_ERROR_OUT       = st_sigerr;
	logic inc_on, inv_on;
	assign inc_on = (cur_mode == cnt_dec_pkg::MODE_INC);
	assign inv_on = ctrl[cnt_dec_pkg::CTRL_INV];
	sequence s_break_hit;
		ctrl[cnt_dec_pkg::CTRL_WIRE] && (|brk_rise);
	endsequence
	sequence s_diag_raised;
		SIGNAL_ERROR_OUT && DIAG_INT_OUT;
	endsequence
	a_never_both: assert property (!(COUNT_UP_OUT && COUNT_DOWN_OUT))
		else $error("Up and down pulse together");
	a_filter_agree: assert property ($changed(filt[cnt_dec_pkg::IDX_A]) |->
		$past(sync2[cnt_dec_pkg::IDX_A] == sync3[cnt_dec_pkg::IDX_A]))
		else $error("Filter moved without stage agreement");
	a_single_up: assert property (
		inc_on && cur_eval == cnt_dec_pkg::EVAL_SINGLE && a_rise && !b_edge && !b_lvl
		&& !inv_on |=> COUNT_UP_OUT) else $error("Single evaluation missed up pulse");
	a_single_down: assert property (
		inc_on && cur_eval == cnt_dec_pkg::EVAL_SINGLE && a_edge && !a_lvl && !b_edge
		&& !b_lvl && !inv_on |=> COUNT_DOWN_OUT) else $error("Single missed down pulse");
	a_double_dir: assert property (
		inc_on && cur_eval == cnt_dec_pkg::EVAL_DOUBLE && a_edge && !b_edge && !inv_on
		|=> COUNT_UP_OUT == $past(a_lvl ^ b_lvl)) else $error("Double direction wrong");
	a_quad_each: assert property (
		inc_on && cur_eval == cnt_dec_pkg::EVAL_QUAD && (a_edge ^ b_edge)
		|=> COUNT_UP_OUT || COUNT_DOWN_OUT) else $error("Quadruple edge not counted");
	a_jump_fault: assert property (
		inc_on && a_edge && b_edge |=> ENCODER_FAULT_FLAG_OUT && !COUNT_UP_OUT
		&& !COUNT_DOWN_OUT) else $error("Invalid transition not flagged");
	a_invert_swap: assert property (
		inc_on && cur_eval == cnt_dec_pkg::EVAL_SINGLE && a_rise && !b_edge && !b_lvl
		&& inv_on |=> COUNT_DOWN_OUT) else $error("Inversion not applied");
	a_pulse_dir: assert property (
		cur_mode == cnt_dec_pkg::MODE_PULSE && ctrl[cnt_dec_pkg::CTRL_DIREN] && a_rise
		&& !inv_on |=> COUNT_DOWN_OUT == $past(b_lvl) && COUNT_UP_OUT != $past(b_lvl))
		else $error("Pulse mode direction wrong");
	a_updown_b: assert property (
		cur_mode == cnt_dec_pkg::MODE_UPDOWN && b_rise && !a_rise && !inv_on
		|=> COUNT_DOWN_OUT) else $error("Down input not counted");
	a_ref_load: assert property (
		inc_on && n_rise && cur_ref == cnt_dec_pkg::REF_LOAD |=> LOAD_START_OUT
		&& !CAPTURE_OUT) else $error("Reference mark did not load");
	a_break_diag: assert property (
		s_break_hit ##0 ctrl[cnt_dec_pkg::CTRL_DIAG] |=> s_diag_raised)
		else $error("Signal error without diagnostic interrupt");
	a_break_flag: assert property (s_break_hit |=> SIGNAL_ERROR_OUT [*2])
		else $error("Wire break not held as signal error");
endmodule : count_signal_decoder

/* cnt_dec_pkg.sv */
// Register map, field layout, input order and mode encodings of the count signal decoder
package cnt_dec_pkg;
	localparam int              ADDR_W      = 8;                 // AXI byte address width
	localparam logic [7:0]      OFS_CTRL    = 8'h00;             // Control register
	localparam logic [7:0]      OFS_STATUS  = 8'h04;             // Status register
	localparam logic [31:0]     CTRL_RESET  = 32'h00000000;      // Control value after reset
	localparam logic [31:0]     CTRL_MASK   = 32'h000007FF;      // Implemented control bits
	localparam int              CTRL_MODE   = 0;                 // Encoder kind, 2 bits
	localparam int              CTRL_EVAL   = 2;                 // Evaluation, 2 bits
	localparam int              CTRL_REF    = 4;                 // Reference action, 2 bits
	localparam int              CTRL_INV    = 6;                 // Invert direction
	localparam int              CTRL_SWDIR  = 7;                 // Software direction, 1 = down
	localparam int              CTRL_DIREN  = 8;                 // Track B carries direction
	localparam int              CTRL_DIAG   = 9;                 // Diagnostic interrupt enable
	localparam int              CTRL_WIRE   = 10;                // Wire break monitor enable
	localparam int              STAT_FAULT  = 0;                 // Encoder fault, sticky W1C
	localparam int              STAT_SIGERR = 1;                 // Signal error, sticky W1C
	localparam int              STAT_LVL    = 4;                 // Filtered A, B, N levels
	localparam int              NUM_IN      = 6;                 // A, B, N and three breaks
	localparam int              IDX_A       = 0;                 // Track A position
	localparam int              IDX_B       = 1;                 // Track B position
	localparam int              IDX_N       = 2;                 // Reference mark position
	localparam int              IDX_BRK     = 3;                 // First wire break flag
	localparam int              NUM_BRK     = 3;                 // Wire break flags
	localparam logic [2:0]      SETTLE_MAX  = 3'h5;              // Cycles until filters hold pins
	localparam logic [1:0]      RESP_OKAY   = 2'h0;              // AXI okay
	localparam logic [1:0]      RESP_SLVERR = 2'h2;              // AXI slave error
	// Encoder kinds
	typedef enum logic [1:0] {MODE_INC, MODE_PULSE, MODE_UPDOWN} enc_mode_t;
	// Incremental evaluation
	typedef enum logic [1:0] {EVAL_SINGLE, EVAL_DOUBLE, EVAL_QUAD} eval_t;
	// Reference mark action
	typedef enum logic [1:0] {REF_NONE, REF_LOAD, REF_CAPTURE} ref_act_t;
endpackage : cnt_dec_pkg

/* enc_model.sv */
// Encoder model: moves one track per step, or both at once when told to misbehave
`timescale 1ns/100ps
module enc_model (
	input  wire logic clk_in,   // Bench clock, pins move just after its edge
	input  wire logic rst_n_in, // Asynchronous reset, active low
	input  wire logic step_in,  // Move one track at this edge
	input  wire logic track_in, // 0 moves A, 1 moves B
	input  wire logic jump_in,  // Faulty move of both tracks together
	input  wire logic mark_in,  // Reference mark level
	output logic      a_out,    // Track A, pulse or up input
	output logic      b_out,    // Track B, direction or down input
	output logic      n_out     // Reference mark
);
	logic next_a; // Track A after this edge
	logic next_b; // Track B after this edge
	// A single track per step keeps A and B a quarter period apart
	always_comb begin
		next_a = a_out ^ ((step_in & !track_in) | jump_in);
		next_b = b_out ^ ((step_in & track_in) | jump_in);
	end
	// Pins rest low after reset, so the decoder sees no edge at release
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			a_out <= 1'h0;
			b_out <= 1'h0;
			n_out <= 1'h0;
		end else begin
			a_out <= next_a;
			b_out <= next_b;
			n_out <= mark_in;
		end
	end
endmodule : enc_model

/* count_signal_decoder_test.sv */
// Self-checking bench of the count signal decoder: random encoder walks and register access
`timescale 1ns/100ps
module count_signal_decoder_test;
	logic        clk = 1'h0;                       // 200 MHz clock
	logic        rst_n;                            // Reset, active low
	logic        step = 1'h0;                      // Model step request
	logic        track = 1'h0;                     // Model track choice
	logic        jump = 1'h0;                      // Model fault request
	logic        mark = 1'h0;                      // Model reference mark
	logic        enc_a, enc_b, enc_n;              // Encoder pins
	logic [2:0]  brk = 3'h0;                       // Wire break flags
	logic [3:0]  wstrb = 4'hF;                     // Write byte strobes
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;   // Bus addresses
	logic [31:0] wdata = 32'h0, rdat, rdata;       // Bus data and captured read
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;               // Responses and captured one
	logic        up, dn, ld, cp, fault, sigerr, diag;
	logic        ha, hw, hb;                       // Handshakes seen before an edge
	int          n_up = 0, n_dn = 0, n_ld = 0, n_cp = 0, n_diag = 0;
	int          n_errors = 0, total_checks = 0;
	logic [31:0] lfsr = 32'hB950;                  // Random source, fixed seed

	always #2.5 clk = ~clk;

	// Pulses are counted per cycle, so a stretched pulse shows as an extra count
	always_ff @(posedge clk) begin
		n_up <= n_up + 32'(up);
		n_dn <= n_dn + 32'(dn);
		n_ld <= n_ld + 32'(ld);
		n_cp <= n_cp + 32'(cp);
		n_diag <= n_diag + 32'(diag);
	end

	enc_model i_enc_model (.clk_in(clk), .rst_n_in(rst_n), .step_in(step), .track_in(track),
		.jump_in(jump), .mark_in(mark), .a_out(enc_a), .b_out(enc_b), .n_out(enc_n));

	count_signal_decoder i_count_signal_decoder (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
		.ENC_A_IN(enc_a), .ENC_B_IN(enc_b), .ENC_N_IN(enc_n), .WIRE_BREAK_IN(brk),
		.S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
		.S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
		.S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
		.S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
		.S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rresp),
		.S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready), .COUNT_UP_OUT(up),
		.COUNT_DOWN_OUT(dn), .LOAD_START_OUT(ld), .CAPTURE_OUT(cp),
		.ENCODER_FAULT_FLAG_OUT(fault), .SIGNAL_ERROR_OUT(sigerr), .DIAG_INT_OUT(diag));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd

	// Expected {up, down} for one pin move under control word c
	function automatic logic [1:0] expect_pulse(input logic [31:0] c, input logic pa, pb, a, b);
		logic u;
		logic d;
		logic t;
		u = 1'h0;
		d = 1'h0;
		case (c[1:0])
			2'h0: begin
				if (a != pa && (c[3:2] != 2'h0 || !b)) begin
					u = a ^ b;
					d = !u;
				end
				if (b != pb && c[3:2] == 2'h2) begin
					u = a == b;
					d = !u;
				end
			end
			2'h1: if (a & !pa) begin
				d = c[8] ? b : c[7];
				u = !d;
			end
			default: begin
				u = a & !pa;
				d = b & !pb;
			end
		endcase
		if (c[6]) begin
			t = u;
			u = d;
			d = t;
		end
		return {u, d};
	endfunction : expect_pulse

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// One bus write; handshakes are judged on values settled before the edge
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		int k;
		@(posedge clk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			ha = awvalid & awready;
			hw = wvalid & wready;
			hb = bvalid;
			resp = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'h0;
			if (hw) wvalid <= 1'h0;
			if (hb) break;
		end
		bready <= 1'h0;
		if (k == 40) begin
			n_errors++;
			end_of_test();
		end
	endtask : wr

	task automatic rd(input logic [7:0] ad);
		int k;
		@(posedge clk);
		araddr <= ad;
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			ha = arvalid & arready;
			hb = rvalid;
			rdata = rdat;
			resp = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'h0;
			if (hb) break;
		end
		rready <= 1'h0;
		if (k == 40) begin
			n_errors++;
			end_of_test();
		end
	endtask : rd

	// One encoder move with a random track and a random, legal gap afterwards
	task automatic mv(input logic jmp);
		logic [31:0] r;
		r = rnd();
		@(posedge clk);
		step <= !jmp;
		track <= r[0];
		jump <= jmp;
		@(posedge clk);
		step <= 1'h0;
		jump <= 1'h0;
		tick(2 + int'(r[3:1]));
	endtask : mv

	initial begin
		#400000;
		n_errors++;
		end_of_test();
	end

	initial begin
		logic [31:0] ctrl;
		logic [1:0]  ex;
		logic        pa, pb;
		int          eu, ed, bu, bd, k;
		rst_n = 1'h0;
		tick(20);
		rst_n <= 1'h1;
		tick(20);
		rd(cnt_dec_pkg::OFS_CTRL);
		check("ctrl reset", rdata, cnt_dec_pkg::CTRL_RESET);
		rd(8'h08);
		check("unmapped read resp", {30'h0, resp}, {30'h0, cnt_dec_pkg::RESP_SLVERR});
		wr(8'h0C, 32'hFFFFFFFF);
		check("unmapped write resp", {30'h0, resp}, {30'h0, cnt_dec_pkg::RESP_SLVERR});
		// Every kind and evaluation, random inversion and direction source, no mark track
		for (k = 0; k < 27; k++) begin
			ctrl = rnd() & 32'h000001C0;
			ctrl[1:0] = 2'(k % 3);
			ctrl[3:2] = 2'((k / 3) % 3);
			wr(cnt_dec_pkg::OFS_CTRL, ctrl);
			rd(cnt_dec_pkg::OFS_CTRL);
			check("ctrl readback", rdata, ctrl);
			eu = 0;
			ed = 0;
			bu = n_up;
			bd = n_dn;
			repeat (16) begin
				pa = enc_a;
				pb = enc_b;
				mv(1'h0);
				ex = expect_pulse(ctrl, pa, pb, enc_a, enc_b);
				eu += int'(ex[1]);
				ed += int'(ex[0]);
			end
			tick(10);
			check("up pulses", n_up - bu, eu);
			check("down pulses", n_dn - bd, ed);
		end
		// Both tracks move together in quadruple mode: no count, fault raised
		wr(cnt_dec_pkg::OFS_CTRL, 32'h00000008);
		bu = n_up + n_dn;
		mv(1'h1);
		tick(10);
		check("fault flag", fault, 1'h1);
		check("count on fault", n_up + n_dn - bu, 0);
		rd(cnt_dec_pkg::OFS_STATUS);
		check("status fault", rdata[cnt_dec_pkg::STAT_FAULT], 1'h1);
		check("status levels", rdata[cnt_dec_pkg::STAT_LVL +: 3], {enc_n, enc_b, enc_a});
		// A status write without the low byte lane leaves the flag alone
		wstrb <= 4'hE;
		wr(cnt_dec_pkg::OFS_STATUS, 32'h00000001);
		check("fault kept", fault, 1'h1);
		wstrb <= 4'hF;
		wr(cnt_dec_pkg::OFS_STATUS, 32'h00000001);
		tick(2);
		check("fault cleared", fault, 1'h0);
		// Reference mark with load, then capture
		for (k = 1; k < 3; k++) begin
			wr(cnt_dec_pkg::OFS_CTRL, 32'(k) << 4);
			bu = n_ld;
			bd = n_cp;
			mark <= 1'h1;
			tick(10);
			mark <= 1'h0;
			tick(10);
			check("load pulses", n_ld - bu, k == 1);
			check("capture pulses", n_cp - bd, k == 2);
		end
		// Wire break with the diagnostic interrupt on, then off
		for (k = 0; k < 2; k++) begin
			wr(cnt_dec_pkg::OFS_CTRL, (k == 0) ? 32'h00000600 : 32'h00000400);
			bu = n_diag;
			brk <= 3'h2;
			tick(12);
			check("signal error", sigerr, 1'h1);
			check("diag pulses", n_diag - bu, k == 0);
			brk <= 3'h0;
			tick(12);
			wr(cnt_dec_pkg::OFS_STATUS, 32'h00000002);
			tick(2);
			check("signal error cleared", sigerr, 1'h0);
		end
		end_of_test();
	end
endmodule : count_signal_decoder_test
